// *** inc/power_seq_pkg.sv ***
// constants and types shared by the four-rail power sequencer
// Notes on behaviour
// - the first enable rises only after the main rail has been high without a break for the long delay.
// - in power-up the second enable rises once the second rail is qualified high, with only the short filter.
// - in power-up the third enable rises once the third rail is qualified high, with only the short filter.
// - power-good rises once all four rails have been high without a break for the long delay.
// - once power-good is reached it falls as soon as any of the four rails reads low.
// - once power-good is reached a main-rail low drops all three enables; other rails leave them on.
// - the second and third enable stages advance only after the main rail and the next rail are both high for 30 us.
// - from power-good a 30 us low on rails two to four goes back to three-enables-on; on the main rail to reset.
// - power-good enters a monitoring mode in which the enables follow the main rail and power-good follows all four rails.
package power_seq_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LONG_DELAY_MS = 190;
  localparam int unsigned LONG_DELAY_MIN_MS = 100;
  localparam int unsigned LONG_DELAY_MAX_MS = 280;
  localparam int unsigned SHORT_DELAY_US = 30;
  localparam int unsigned LONG_DELAY_CYCLES = LONG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SHORT_DELAY_CYCLES = SHORT_DELAY_US * CLK_MHZ;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned RAIL_COUNT = 4;

  localparam logic [RAIL_COUNT-1:0] RAILS_RESET = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEQ_RESET,
    SEQ_FIRST_ON,
    SEQ_TWO_ON,
    SEQ_THREE_ON,
    SEQ_POWER_GOOD
  } seq_state_t;

endpackage

// *** inc/qual_timer_if.sv ***
// link between the sequencer and one qualification timer
`timescale 1ns/10ps
`default_nettype none
interface qual_timer_if;
  logic restart;
  logic hold;
  logic [power_seq_pkg::COUNT_W-1:0] limit;
  logic expired;

  modport ctrl (output restart, output hold, output limit, input expired);
  modport timer (input restart, input hold, input limit, output expired);
endinterface
`default_nettype wire

// *** rtl/power_sequencer.sv ***
// four-rail supply sequencer and power-good monitor
`timescale 1ns/10ps
`default_nettype none
module power_sequencer #(
  parameter logic [31:0] LONG_CYCLES = power_seq_pkg::LONG_DELAY_CYCLES,
  parameter logic [31:0] SHORT_CYCLES = power_seq_pkg::SHORT_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_rail_sense,
  input wire logic second_rail_sense,
  input wire logic third_rail_sense,
  input wire logic final_rail_sense,
  input wire logic first_regulator_enable_in,
  output logic first_regulator_enable_out,
  output logic first_regulator_enable_oe,
  input wire logic second_regulator_enable_in,
  output logic second_regulator_enable_out,
  output logic second_regulator_enable_oe,
  input wire logic third_regulator_enable_in,
  output logic third_regulator_enable_out,
  output logic third_regulator_enable_oe,
  input wire logic system_power_good_in,
  output logic system_power_good_out,
  output logic system_power_good_oe,
  output logic [2:0] sequence_state
);

  localparam int unsigned NR = power_seq_pkg::RAIL_COUNT;

  logic [NR-1:0] rail_raw;
  logic [NR-1:0] rail_meta;
  logic [NR-1:0] rail;
  logic main_hi;
  logic second_hi;
  logic third_hi;
  logic final_hi;
  logic aux_all_hi;
  logic all_hi;

  power_seq_pkg::seq_state_t state;
  power_seq_pkg::seq_state_t next_state;

  logic en1;
  logic en2;
  logic en3;
  logic pgood;
  logic next_en1;
  logic next_en2;
  logic next_en3;
  logic next_pgood;
  logic pin_readback_unused;

  qual_timer_if tmr_a ();
  qual_timer_if tmr_b ();

  assign rail_raw = {final_rail_sense, third_rail_sense,
                     second_rail_sense, main_rail_sense};

  // two-stage synchroniser per rail; the comparators are asynchronous
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rail_meta <= power_seq_pkg::RAILS_RESET;
      rail <= power_seq_pkg::RAILS_RESET;
    end else begin
      rail_meta <= rail_raw;
      rail <= rail_meta;
    end
  end

  assign main_hi = rail[0];
  assign second_hi = rail[1];
  assign third_hi = rail[2];
  assign final_hi = rail[3];
  assign aux_all_hi = second_hi && third_hi && final_hi;
  assign all_hi = main_hi && aux_all_hi;

  // timer a: the long delays in power-up, main-rail fault in power-good
  // timer b: stage filters in power-up, other-rail fault in power-good
  always_comb begin
    tmr_a.hold = 1'b0;
    tmr_a.limit = LONG_CYCLES;
    tmr_b.hold = 1'b0;
    tmr_b.limit = SHORT_CYCLES;
    case (state)
      power_seq_pkg::SEQ_RESET: begin
        tmr_a.hold = main_hi;
      end
      power_seq_pkg::SEQ_FIRST_ON: begin
        tmr_b.hold = main_hi && second_hi;
      end
      power_seq_pkg::SEQ_TWO_ON: begin
        tmr_b.hold = main_hi && third_hi;
      end
      power_seq_pkg::SEQ_THREE_ON: begin
        tmr_a.hold = all_hi;
      end
      power_seq_pkg::SEQ_POWER_GOOD: begin
        // the long delay plays no part once power-good is reached
        tmr_a.hold = !main_hi;
        tmr_a.limit = SHORT_CYCLES;
        tmr_b.hold = !aux_all_hi;
      end
      default: begin
        tmr_a.hold = 1'b0;
      end
    endcase
  end

  // a state change restarts both waits so no qualification carries over
  assign tmr_a.restart = (next_state != state);
  assign tmr_b.restart = (next_state != state);

  qual_timer u_timer_a (
    .core_clk(core_clk),
    .rstn(rstn),
    .tmr(tmr_a)
  );

  qual_timer u_timer_b (
    .core_clk(core_clk),
    .rstn(rstn),
    .tmr(tmr_b)
  );

  always_comb begin
    next_state = state;
    case (state)
      power_seq_pkg::SEQ_RESET: begin
        if (tmr_a.expired) begin
          next_state = power_seq_pkg::SEQ_FIRST_ON;
        end
      end
      power_seq_pkg::SEQ_FIRST_ON: begin
        if (tmr_b.expired) begin
          next_state = power_seq_pkg::SEQ_TWO_ON;
        end
      end
      power_seq_pkg::SEQ_TWO_ON: begin
        if (tmr_b.expired) begin
          next_state = power_seq_pkg::SEQ_THREE_ON;
        end
      end
      power_seq_pkg::SEQ_THREE_ON: begin
        if (tmr_a.expired) begin
          next_state = power_seq_pkg::SEQ_POWER_GOOD;
        end
      end
      power_seq_pkg::SEQ_POWER_GOOD: begin
        // a main-rail fault outranks a fault on the other rails
        if (tmr_a.expired) begin
          next_state = power_seq_pkg::SEQ_RESET;
        end else if (tmr_b.expired) begin
          next_state = power_seq_pkg::SEQ_THREE_ON;
        end
      end
      default: begin
        next_state = power_seq_pkg::SEQ_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= power_seq_pkg::SEQ_RESET;
    end else begin
      state <= next_state;
    end
  end

  // outputs are decoded from the state being entered, so they change on
  // the same edge as the state itself
  always_comb begin
    next_en1 = 1'b0;
    next_en2 = 1'b0;
    next_en3 = 1'b0;
    next_pgood = 1'b0;
    case (next_state)
      power_seq_pkg::SEQ_RESET: begin
        next_en1 = 1'b0;
      end
      power_seq_pkg::SEQ_FIRST_ON: begin
        next_en1 = 1'b1;
      end
      power_seq_pkg::SEQ_TWO_ON: begin
        next_en1 = 1'b1;
        next_en2 = 1'b1;
      end
      power_seq_pkg::SEQ_THREE_ON: begin
        next_en1 = 1'b1;
        next_en2 = 1'b1;
        next_en3 = 1'b1;
      end
      power_seq_pkg::SEQ_POWER_GOOD: begin
        // monitoring mode: enables hang on the main rail only
        next_en1 = main_hi;
        next_en2 = main_hi;
        next_en3 = main_hi;
        next_pgood = all_hi;
      end
      default: begin
        next_pgood = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en1 <= 1'b0;
      en2 <= 1'b0;
      en3 <= 1'b0;
      pgood <= 1'b0;
    end else begin
      en1 <= next_en1;
      en2 <= next_en2;
      en3 <= next_en3;
      pgood <= next_pgood;
    end
  end

  // open-drain: pull low while deasserted, release to the pull-up when high
  assign first_regulator_enable_out = 1'b0;
  assign first_regulator_enable_oe = !en1;
  assign second_regulator_enable_out = 1'b0;
  assign second_regulator_enable_oe = !en2;
  assign third_regulator_enable_out = 1'b0;
  assign third_regulator_enable_oe = !en3;
  assign system_power_good_out = 1'b0;
  assign system_power_good_oe = !pgood;
  assign sequence_state = state;

  // the pin levels are not needed: a wired-low from outside does not
  // change the sequence
  assign pin_readback_unused = first_regulator_enable_in
    ^ second_regulator_enable_in ^ third_regulator_enable_in
    ^ system_power_good_in;

endmodule
`default_nettype wire

// *** rtl/qual_timer.sv ***
// counts how long a condition has held without a break
`timescale 1ns/10ps
`default_nettype none
module qual_timer (
  input wire logic core_clk,
  input wire logic rstn,
  qual_timer_if.timer tmr
);

  logic [power_seq_pkg::COUNT_W-1:0] count;
  logic [power_seq_pkg::COUNT_W-1:0] last;

  // any break in the condition starts the wait over
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= power_seq_pkg::COUNT_RESET;
    end else if (tmr.restart || !tmr.hold) begin
      count <= power_seq_pkg::COUNT_RESET;
    end else if (count != last) begin
      count <= count + 1'b1;
    end
  end

  // a limit of zero is treated as one cycle
  assign last = (tmr.limit == '0) ? '0 : tmr.limit - 1'b1;
  // expired must not look at restart: the owner decodes restart from the
  // state change that expired itself causes, which would close a loop
  assign tmr.expired = tmr.hold && (count == last);

endmodule
`default_nettype wire

// *** sim/power_sequencer_properties.sv ***
// assertions on the sequencer's pins and state
`timescale 1ns/10ps
`default_nettype none
module power_sequencer_properties #(
  parameter logic [31:0] LONG_CYCLES = 32'h0000_0032,
  parameter logic [31:0] SHORT_CYCLES = 32'h0000_0005
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_rail_sense,
  input wire logic second_rail_sense,
  input wire logic third_rail_sense,
  input wire logic final_rail_sense,
  input wire logic first_regulator_enable_in,
  input wire logic first_regulator_enable_out,
  input wire logic first_regulator_enable_oe,
  input wire logic second_regulator_enable_in,
  input wire logic second_regulator_enable_out,
  input wire logic second_regulator_enable_oe,
  input wire logic third_regulator_enable_in,
  input wire logic third_regulator_enable_out,
  input wire logic third_regulator_enable_oe,
  input wire logic system_power_good_in,
  input wire logic system_power_good_out,
  input wire logic system_power_good_oe,
  input wire logic [2:0] sequence_state
);
  logic m;
  logic o;
  logic [5:0] c;
  int run [6];
  assign m = main_rail_sense;
  assign o = second_rail_sense && third_rail_sense && final_rail_sense;
  assign c = {!o, !m, m, m && second_rail_sense, m && third_rail_sense,
    m && o};
  // raw run lengths; the two-flop lag is covered by looking two cycles back
  always_ff @(posedge core_clk or negedge rstn) begin
    for (int i = 0; i < 6; i++) begin
      if (!rstn) begin
        run[i] <= 0;
      end else begin
        run[i] <= c[i] ? run[i] + 1 : 0;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property step_p(logic [2:0] a, logic [2:0] b, int i, int l);
    $past(sequence_state) == a && sequence_state == b
      |-> $past(run[i], 2) >= l;
  endproperty
  first_enable_a: assert property (step_p(0, 1, 3, LONG_CYCLES))
    else $error("first enable came too early");
  second_enable_a: assert property (step_p(1, 2, 2, SHORT_CYCLES))
    else $error("second enable came too early");
  third_enable_a: assert property (step_p(2, 3, 1, SHORT_CYCLES))
    else $error("third enable came too early");
  pgood_delay_a: assert property (step_p(3, 4, 0, LONG_CYCLES))
    else $error("power good came too early");
  main_fault_a: assert property (step_p(4, 0, 4, SHORT_CYCLES))
    else $error("reset entered without a long main low");
  rail_fault_a: assert property (step_p(4, 3, 5, SHORT_CYCLES))
    else $error("power good left without a long rail low");
  pgood_drop_a: assert property (sequence_state == 3'h4 && !c[0]
    |-> ##3 system_power_good_oe) else $error("power good not dropped");
  main_drop_a: assert property (sequence_state == 3'h4 && !m |-> ##3
    first_regulator_enable_oe && second_regulator_enable_oe
    && third_regulator_enable_oe) else $error("enables not dropped");
  keep_on_a: assert property ((sequence_state == 3'h4 && m)[*4]
    |-> !(first_regulator_enable_oe || second_regulator_enable_oe
    || third_regulator_enable_oe)) else $error("enables dropped");
  pgood_state_a: assert property (!system_power_good_oe
    |-> sequence_state == 3'h4) else $error("power good outside state");
  cover property (sequence_state == 3'h4);
  cover property ($past(sequence_state) == 3'h4 && sequence_state == 3'h3);
  cover property ($past(sequence_state) == 3'h4 && sequence_state == 3'h0);
endmodule
bind power_sequencer power_sequencer_properties #(
  .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) chk_u (.*);
`default_nettype wire

// *** sim/rail_regulators.sv ***
// three regulators whose outputs feed the downstream rail senses
`timescale 1ns/10ps
`default_nettype none
module rail_regulators (
  input wire logic core_clk,
  input wire logic [2:0] en,
  input wire logic [2:0] kill,
  input wire logic [7:0] lag,
  output logic [2:0] rail = 3'h0
);
  logic [7:0] age [3];
  // a rail rises only after lag cycles of steady enable, drops at once
  always @(posedge core_clk)
    for (int i = 0; i < 3; i++) begin
      age[i] <= !en[i] ? 8'h00 : age[i] == 8'hFF ? age[i] : age[i] + 8'h01;
      rail[i] <= en[i] && !kill[i] && age[i] >= lag;
    end
endmodule
`default_nettype wire

// *** sim/test_power_sequencer.sv ***
// self-checking bench for the four-rail sequencer
`timescale 1ns/10ps
`default_nettype none
module test_power_sequencer;
  localparam logic [31:0] LC = 32'h0000_0032;
  localparam logic [31:0] SC = 32'h0000_0005;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic main = 1'b0;
  logic [2:0] kill = 3'h0;
  logic [7:0] lag = 8'h00;
  logic [2:0] rail;
  wire logic [3:0] oe;
  wire logic [3:0] out;
  // a pin that nobody pulls low sits at its pull-up level
  wire logic [3:0] pin = ~oe | out;
  logic [2:0] sequence_state;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  int k;
  always #2.5 core_clk = ~core_clk;
  rail_regulators bank_u (.core_clk(core_clk), .en(pin[2:0]), .kill(kill),
    .lag(lag), .rail(rail));
  power_sequencer #(.LONG_CYCLES(LC), .SHORT_CYCLES(SC)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .main_rail_sense(main),
    .second_rail_sense(rail[0]), .third_rail_sense(rail[1]),
    .final_rail_sense(rail[2]), .first_regulator_enable_in(pin[0]),
    .first_regulator_enable_out(out[0]), .first_regulator_enable_oe(oe[0]),
    .second_regulator_enable_in(pin[1]),
    .second_regulator_enable_out(out[1]),
    .second_regulator_enable_oe(oe[1]), .third_regulator_enable_in(pin[2]),
    .third_regulator_enable_out(out[2]), .third_regulator_enable_oe(oe[2]),
    .system_power_good_in(pin[3]), .system_power_good_out(out[3]),
    .system_power_good_oe(oe[3]), .sequence_state(sequence_state));
  function automatic logic [3:0] pins(input logic [2:0] st);
    logic [4:0] t;
    t = (5'h01 << st) - 5'h01;
    return t[3:0];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic reach(input logic [2:0] st);
    n = 0;
    while (sequence_state !== st && n < 2000) begin
      cyc(1);
      n++;
    end
    check("state", sequence_state, st);
    check("pins", pin, pins(st));
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    n = $urandom(32'hB2ED0179);
    for (int r = 0; r < 4; r++) begin
      rstn = 1'b0;
      main = 1'b0;
      kill = 3'h0;
      lag = 8'($urandom_range(0, 30));
      cyc(2);
      check("reset", {sequence_state, pin}, 7'h00);
      rstn = 1'b1;
      main = 1'b1;
      // a one-cycle dip must restart the long qualification
      cyc($urandom_range(1, 40));
      main = 1'b0;
      cyc(1);
      main = 1'b1;
      reach(3'h1);
      check("long", n inside {[LC + 2:LC + 3]}, 1'b1);
      reach(3'h2);
      reach(3'h3);
      reach(3'h4);
      check("pg_wait", n >= LC, 1'b1);
      k = $urandom_range(0, 2);
      kill[k] = 1'b1;
      cyc(2);
      kill = 3'h0;
      cyc(2);
      check("glitch", {sequence_state, pin}, 7'h47);
      cyc(4);
      check("restore", {sequence_state, pin}, 7'h4F);
      kill[k] = 1'b1;
      reach(3'h3);
      kill = 3'h0;
      reach(3'h4);
      check("rewait", n >= LC, 1'b1);
      // the dip drops the enables for a cycle; a regulator slower than
      // four cycles to recover would look like a genuine rail fault
      lag = 8'($urandom_range(0, 3));
      main = 1'b0;
      cyc(1);
      main = 1'b1;
      cyc(2);
      check("main_dip", {sequence_state, pin}, 7'h40);
      cyc(4);
      main = 1'b0;
      reach(3'h0);
      check("short", n inside {[SC + 2:SC + 3]}, 1'b1);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
